// ### hdl/dpc_defs.vh
// Constants shared by the defective pixel correction block.
// Assumes it is included by bare name from hdl/ design files and from the top bench.
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH

// Table geometry
`define DPC_DEPTH        16           // Entries in every table copy
`define DPC_IDXW         4            // Entry index width
`define DPC_CNTW         5            // Entry count width, 0..16
`define DPC_CW           12           // Coordinate width
`define DPC_PW           12           // Pixel width
`define DPC_EW           24           // Entry layout {row, col}

// Register byte offsets on the AXI4-Lite bus
`define DPC_AW           8
`define DPC_A_CTRL       8'h00
`define DPC_A_COUNT      8'h04
`define DPC_A_SELECT     8'h08
`define DPC_A_COL        8'h0C
`define DPC_A_ROW        8'h10
`define DPC_A_CMD        8'h14
`define DPC_A_STATUS     8'h18
`define DPC_A_WINOFS     8'h1C

// Control fields
`define DPC_CTRL_ON      0            // static_table_correct_on
`define DPC_CTRL_DYN     1            // dynamic_correct_on, stored only
`define DPC_CTRL_METH_HI 3            // replace_method field
`define DPC_CTRL_METH_LO 2
`define DPC_METH_AVG     2'h0
`define DPC_METH_HIGH    2'h1
`define DPC_WIN_ROW_LO   16           // Row offset field of WINOFS

// Command bits, write-one-to-start
`define DPC_CMD_COMMIT   0            // commit_active_table
`define DPC_CMD_STORE    1            // store_table_persistent
`define DPC_CMD_FACTORY  2            // factory restore

// Status fields
`define DPC_ST_BUSY      0
`define DPC_ST_CNT_LO    8

// Bus responses
`define DPC_RESP_OKAY    2'h0
`define DPC_RESP_SLVERR  2'h2

// Factory calibrated contents, {row, col}
`define DPC_FACT_COUNT   5'h02
`define DPC_FACT_E0      24'h00_1020
`define DPC_FACT_E1      24'h00_4008

`endif

// ### hdl/dpc_pix.v
// Pixel stream stage: finds listed pixels and replaces them.
// Assumes a same-clock pixel stream and a table held steady by the caller.
`timescale 1ns/100ps
`include "dpc_defs.vh"

module dpc_pix (
    input  wire                            mclk,
    input  wire                            rst_b,
    input  wire                            ce,
    input  wire                            corr_on,
    input  wire [1:0]                      method,
    input  wire [`DPC_CW-1:0]              ofs_col,
    input  wire [`DPC_CW-1:0]              ofs_row,
    input  wire [`DPC_CNTW-1:0]            act_cnt,
    input  wire [`DPC_DEPTH*`DPC_EW-1:0]   act_flat,
    input  wire                            pix_valid,
    input  wire                            pix_sof,
    input  wire                            pix_eol,
    input  wire [`DPC_PW-1:0]              pix_data,
    output reg                             pixo_valid,
    output reg                             pixo_sof,
    output reg                             pixo_eol,
    output reg  [`DPC_PW-1:0]              pixo_data
);

////////////////////////////////////////////////////////////////////////////////
// State
reg  [`DPC_CW-1:0] col_r;             // Position of next input pixel
reg  [`DPC_CW-1:0] row_r;
reg  [`DPC_PW-1:0] left_r;            // Pixel before the centre
reg  [`DPC_PW-1:0] ctr_r;             // Pixel waiting for its right side
reg  [`DPC_CW-1:0] ccol_r;
reg  [`DPC_CW-1:0] crow_r;
reg                ctr_v_r;
reg                ctr_sof_r;
reg                ctr_eol_r;

wire [`DPC_CW-1:0] in_col = pix_sof ? {`DPC_CW{1'b0}} : col_r;
wire [`DPC_CW-1:0] in_row = pix_sof ? {`DPC_CW{1'b0}} : row_r;
// Centre leaves when its right neighbour arrives, or at once after line end
wire emit = ctr_v_r & (pix_valid | ctr_eol_r);
wire has_left  = (ccol_r != {`DPC_CW{1'b0}});
wire has_right = pix_valid & ~ctr_eol_r;

////////////////////////////////////////////////////////////////////////////////
// Entry match: window position plus offset equals full-sensor position
function entry_hit;
    input [`DPC_EW-1:0] ent;
    input [`DPC_CW-1:0] c;
    input [`DPC_CW-1:0] r;
    begin
        // Widened sums so entries outside the window never alias
        entry_hit = ({1'b0, ent[`DPC_CW-1:0]} == ({1'b0, c} + {1'b0, ofs_col})) &&
                    ({1'b0, ent[`DPC_EW-1:`DPC_CW]} == ({1'b0, r} + {1'b0, ofs_row}));
    end
endfunction

reg                hit;
reg  [`DPC_PW:0]   sum;
reg  [`DPC_PW-1:0] avg;
integer            i;

// Hit search over valid active entries and neighbour average
always @* begin
    hit = 1'b0;
    for (i = 0; i < `DPC_DEPTH; i = i + 1) begin
        // Only the first act_cnt entries take part
        if ((i < act_cnt) &&
            entry_hit(act_flat[i*`DPC_EW +: `DPC_EW], ccol_r, crow_r)) begin
            hit = 1'b1;
        end
    end
    // Left/right average; a missing side at a line edge is not counted
    sum = {1'b0, left_r} + {1'b0, pix_data};
    if (has_left && has_right) begin
        avg = sum[`DPC_PW:1];
    end else if (has_left) begin
        avg = left_r;
    end else if (has_right) begin
        avg = pix_data;
    end else begin
        avg = ctr_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stream pipeline, one pixel deep
always @(posedge mclk) begin
    if (!rst_b) begin
        col_r      <= {`DPC_CW{1'b0}};
        row_r      <= {`DPC_CW{1'b0}};
        left_r     <= {`DPC_PW{1'b0}};
        ctr_r      <= {`DPC_PW{1'b0}};
        ccol_r     <= {`DPC_CW{1'b0}};
        crow_r     <= {`DPC_CW{1'b0}};
        ctr_v_r    <= 1'b0;
        ctr_sof_r  <= 1'b0;
        ctr_eol_r  <= 1'b0;
        pixo_valid <= 1'b0;
        pixo_sof   <= 1'b0;
        pixo_eol   <= 1'b0;
        pixo_data  <= {`DPC_PW{1'b0}};
    end else if (ce) begin
        pixo_valid <= emit;
        if (emit) begin
            pixo_sof <= ctr_sof_r;
            pixo_eol <= ctr_eol_r;
            if (corr_on && hit) begin
                // Highlight forces full scale, other codes average
                pixo_data <= (method == `DPC_METH_HIGH) ? {`DPC_PW{1'b1}} : avg;
            end else begin
                // Correction off leaves pixels untouched
                pixo_data <= ctr_r;
            end
        end
        if (pix_valid) begin
            left_r    <= ctr_r;
            ctr_r     <= pix_data;
            ccol_r    <= in_col;
            crow_r    <= in_row;
            ctr_v_r   <= 1'b1;
            ctr_sof_r <= pix_sof;
            ctr_eol_r <= pix_eol;
            col_r     <= pix_eol ? {`DPC_CW{1'b0}} : in_col + 1'b1;
            row_r     <= pix_eol ? in_row + 1'b1 : in_row;
        end else if (emit) begin
            // Line end flushed on the first idle cycle
            ctr_v_r <= 1'b0;
        end
    end
end

endmodule

// ### hdl/dpc_top.v
// Defective pixel correction: AXI4-Lite registers, table copies, copy engine.
// Assumes the pixel stream and the bus master both run on mclk.
`timescale 1ns/100ps
`include "dpc_defs.vh"

module dpc_top (
    input  wire                  mclk,
    input  wire                  rst_b,
    input  wire                  ce,
    input  wire [`DPC_AW-1:0]    s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [`DPC_AW-1:0]    s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    input  wire                  pix_valid,
    input  wire                  pix_sof,
    input  wire                  pix_eol,
    input  wire [`DPC_PW-1:0]    pix_data,
    output wire                  pixo_valid,
    output wire                  pixo_sof,
    output wire                  pixo_eol,
    output wire [`DPC_PW-1:0]    pixo_data
);

////////////////////////////////////////////////////////////////////////////////
// Local codes
localparam [1:0] ST_IDLE  = 2'h0;     // Engine free
localparam [1:0] ST_COPY  = 2'h1;     // Walking all entries
localparam [1:0] ST_BOOT  = 2'h2;     // Loading counts after reset
localparam [1:0] SRC_STG  = 2'h0;     // Copy source: staged table
localparam [1:0] SRC_NV   = 2'h1;     // Copy source: persistent table
localparam [1:0] SRC_FACT = 2'h2;     // Copy source: factory contents
localparam [31:0] FULL_CNT = `DPC_DEPTH; // Count of a full table

////////////////////////////////////////////////////////////////////////////////
// Storage
reg  [`DPC_EW-1:0]   stg_tab_r [0:`DPC_DEPTH-1];   // Host-edited copy
reg  [`DPC_EW-1:0]   act_tab_r [0:`DPC_DEPTH-1];   // Volatile copy in use
reg  [`DPC_EW-1:0]   nv_tab_r  [0:`DPC_DEPTH-1];   // Persistent copy, no reset
reg  [`DPC_CNTW-1:0] stg_cnt_r;
reg  [`DPC_CNTW-1:0] act_cnt_r;
reg  [`DPC_CNTW-1:0] nv_cnt_r;
reg  [`DPC_IDXW-1:0] sel_r;                        // table_entry_select
reg                  on_r;                         // static_table_correct_on
reg                  dyn_r;                        // dynamic_correct_on
reg  [1:0]           meth_r;                       // replace_method
reg  [`DPC_CW-1:0]   ofs_col_r;                    // Window column offset
reg  [`DPC_CW-1:0]   ofs_row_r;                    // Window row offset

// Copy engine
reg  [1:0]           state_r;
reg  [1:0]           src_r;
reg  [`DPC_IDXW-1:0] idx_r;
reg                  to_act_r;
reg                  to_stg_r;
reg                  to_nv_r;

// Bus slave
reg                  aw_have_r;
reg                  w_have_r;
reg  [`DPC_AW-1:0]   awaddr_r;
reg  [31:0]          wdata_r;
reg  [3:0]           wstrb_r;

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Apply byte strobes to a register word
function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      b;
    begin
        wmerge = old;
        for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
                wmerge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    end
endfunction

// Read view of every register; also the base for partial writes
function [31:0] reg_read;
    input [`DPC_AW-1:0] a;
    reg   [`DPC_EW-1:0] e;
    begin
        e        = stg_tab_r[sel_r];
        reg_read = 32'h0000_0000;
        case (a)
            `DPC_A_CTRL: begin
                reg_read[`DPC_CTRL_ON]  = on_r;
                reg_read[`DPC_CTRL_DYN] = dyn_r;
                reg_read[`DPC_CTRL_METH_HI:`DPC_CTRL_METH_LO] = meth_r;
            end
            `DPC_A_COUNT:  reg_read[`DPC_CNTW-1:0] = stg_cnt_r;
            `DPC_A_SELECT: reg_read[`DPC_IDXW-1:0] = sel_r;
            // Accessors show the selected staged entry
            `DPC_A_COL:    reg_read[`DPC_CW-1:0]   = e[`DPC_CW-1:0];
            `DPC_A_ROW:    reg_read[`DPC_CW-1:0]   = e[`DPC_EW-1:`DPC_CW];
            `DPC_A_STATUS: begin
                reg_read[`DPC_ST_BUSY] = (state_r != ST_IDLE);
                reg_read[`DPC_ST_CNT_LO +: `DPC_CNTW] = act_cnt_r;
            end
            `DPC_A_WINOFS: begin
                reg_read[`DPC_CW-1:0] = ofs_col_r;
                reg_read[`DPC_WIN_ROW_LO +: `DPC_CW] = ofs_row_r;
            end
            default:       reg_read = 32'h0000_0000;
        endcase
    end
endfunction

// Address is one of the mapped words
function mapped;
    input [`DPC_AW-1:0] a;
    begin
        mapped = (a[1:0] == 2'h0) && (a <= `DPC_A_WINOFS);
    end
endfunction

// Factory calibrated entry by index
function [`DPC_EW-1:0] fact_entry;
    input [`DPC_IDXW-1:0] k;
    begin
        case (k)
            4'h0:    fact_entry = `DPC_FACT_E0;
            4'h1:    fact_entry = `DPC_FACT_E1;
            default: fact_entry = 24'h00_0000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Combinational decode
wire         wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
wire [31:0]  wv      = wmerge(reg_read(awaddr_r), wdata_r, wstrb_r);
wire         idle    = (state_r == ST_IDLE);
wire         cmd_wr  = wr_fire & (awaddr_r == `DPC_A_CMD) & idle;
wire         go_fact = cmd_wr & wv[`DPC_CMD_FACTORY];
wire         go_comm = cmd_wr & ~wv[`DPC_CMD_FACTORY] & wv[`DPC_CMD_COMMIT];
wire         go_stor = cmd_wr & ~wv[`DPC_CMD_FACTORY] & ~wv[`DPC_CMD_COMMIT] &
                       wv[`DPC_CMD_STORE];
wire         copying = (state_r == ST_COPY);
wire [`DPC_CNTW-1:0] cnt_clamp = (wv[`DPC_CNTW-1:0] > `DPC_DEPTH) ?
                                 FULL_CNT[`DPC_CNTW-1:0] : wv[`DPC_CNTW-1:0];

reg  [`DPC_EW-1:0]   copy_src;
reg  [`DPC_DEPTH*`DPC_EW-1:0] act_flat;
integer              j;

// Copy source word and flattened active table
always @* begin
    case (src_r)
        SRC_STG: copy_src = stg_tab_r[idx_r];
        SRC_NV:  copy_src = nv_tab_r[idx_r];
        default: copy_src = fact_entry(idx_r);
    endcase
    for (j = 0; j < `DPC_DEPTH; j = j + 1) begin
        act_flat[j*`DPC_EW +: `DPC_EW] = act_tab_r[j];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave, registers, staged and active tables, copy engine
always @(posedge mclk) begin
    if (!rst_b) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `DPC_RESP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rresp   <= `DPC_RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        aw_have_r     <= 1'b0;
        w_have_r      <= 1'b0;
        awaddr_r      <= {`DPC_AW{1'b0}};
        wdata_r       <= 32'h0000_0000;
        wstrb_r       <= 4'h0;
        sel_r         <= {`DPC_IDXW{1'b0}};
        on_r          <= 1'b0;
        dyn_r         <= 1'b0;
        meth_r        <= `DPC_METH_AVG;
        ofs_col_r     <= {`DPC_CW{1'b0}};
        ofs_row_r     <= {`DPC_CW{1'b0}};
        stg_cnt_r     <= {`DPC_CNTW{1'b0}};
        act_cnt_r     <= {`DPC_CNTW{1'b0}};
        // Power-up: fetch the persistent table first
        state_r       <= ST_BOOT;
        src_r         <= SRC_NV;
        idx_r         <= {`DPC_IDXW{1'b0}};
        to_act_r      <= 1'b1;
        to_stg_r      <= 1'b1;
        to_nv_r       <= 1'b0;
    end else if (ce) begin
        // Address and data taken independently
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r      <= s_axi_awaddr;
            aw_have_r     <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            w_have_r     <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        // Both halves present: write and answer
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? `DPC_RESP_OKAY : `DPC_RESP_SLVERR;
            case (awaddr_r)
                `DPC_A_CTRL: begin
                    on_r   <= wv[`DPC_CTRL_ON];
                    dyn_r  <= wv[`DPC_CTRL_DYN];
                    meth_r <= wv[`DPC_CTRL_METH_HI:`DPC_CTRL_METH_LO];
                end
                // Staged count only; clamps at table depth
                `DPC_A_COUNT:  stg_cnt_r <= cnt_clamp;
                `DPC_A_SELECT: begin
                    // Selector outside 0..N-1 is ignored
                    if ({1'b0, wv[`DPC_IDXW-1:0]} < stg_cnt_r &&
                        wv[31:`DPC_IDXW] == 28'h000_0000) begin
                        sel_r <= wv[`DPC_IDXW-1:0];
                    end
                end
                // Coordinate edits touch staged copy only
                `DPC_A_COL: stg_tab_r[sel_r][`DPC_CW-1:0] <= wv[`DPC_CW-1:0];
                `DPC_A_ROW: stg_tab_r[sel_r][`DPC_EW-1:`DPC_CW] <= wv[`DPC_CW-1:0];
                `DPC_A_WINOFS: begin
                    ofs_col_r <= wv[`DPC_CW-1:0];
                    ofs_row_r <= wv[`DPC_WIN_ROW_LO +: `DPC_CW];
                end
                default: ;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        // Read: answer at the edge that takes the address
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= reg_read(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? `DPC_RESP_OKAY : `DPC_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        // Command starts; a busy engine drops new commands
        if (go_fact) begin
            // Factory contents into every copy
            state_r   <= ST_COPY;
            src_r     <= SRC_FACT;
            to_act_r  <= 1'b1;
            to_stg_r  <= 1'b1;
            to_nv_r   <= 1'b1;
            act_cnt_r <= `DPC_FACT_COUNT;
            stg_cnt_r <= `DPC_FACT_COUNT;
            sel_r     <= {`DPC_IDXW{1'b0}};
        end else if (go_comm) begin
            // Staged table becomes the one in use
            state_r   <= ST_COPY;
            src_r     <= SRC_STG;
            to_act_r  <= 1'b1;
            to_stg_r  <= 1'b0;
            to_nv_r   <= 1'b0;
            act_cnt_r <= stg_cnt_r;
        end else if (go_stor) begin
            // Whole table rewritten, no merge
            state_r   <= ST_COPY;
            src_r     <= SRC_STG;
            to_act_r  <= 1'b0;
            to_stg_r  <= 1'b0;
            to_nv_r   <= 1'b1;
        end
        // Boot: counts from persistent copy, then entries
        if (state_r == ST_BOOT) begin
            act_cnt_r <= nv_cnt_r;
            stg_cnt_r <= nv_cnt_r;
            state_r   <= ST_COPY;
        end
        // One entry per cycle; frames may see a mixed table meanwhile
        if (copying) begin
            if (to_act_r) begin
                act_tab_r[idx_r] <= copy_src;
            end
            if (to_stg_r) begin
                stg_tab_r[idx_r] <= copy_src;
            end
            idx_r <= idx_r + 1'b1;
            if (idx_r == `DPC_DEPTH - 1) begin
                state_r <= ST_IDLE;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Persistent copy: kept apart since it has no reset, like real storage
always @(posedge mclk) begin
    if (ce) begin
        if (go_stor) begin
            nv_cnt_r <= stg_cnt_r;
        end else if (go_fact) begin
            nv_cnt_r <= `DPC_FACT_COUNT;
        end
        if (copying && to_nv_r) begin
            nv_tab_r[idx_r] <= copy_src;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pixel replacement stage, reads only the active copy
dpc_pix u_pix (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .ce         (ce),
    .corr_on    (on_r),
    .method     (meth_r),
    .ofs_col    (ofs_col_r),
    .ofs_row    (ofs_row_r),
    .act_cnt    (act_cnt_r),
    .act_flat   (act_flat),
    .pix_valid  (pix_valid),
    .pix_sof    (pix_sof),
    .pix_eol    (pix_eol),
    .pix_data   (pix_data),
    .pixo_valid (pixo_valid),
    .pixo_sof   (pixo_sof),
    .pixo_eol   (pixo_eol),
    .pixo_data  (pixo_data)
);

endmodule

// ### tb/dpc_src.sv
// Sensor readout model: one frame of W by H random pixels, back to back.
// Assumes go pulses for one cycle while no frame runs.
`timescale 1ns/100ps
module dpc_src #(parameter int W = 40, parameter int H = 5) (
    input  wire logic        mclk,
    input  wire logic        go,
    output logic             pix_valid = 1'b0,
    output logic             pix_sof = 1'b0,
    output logic             pix_eol = 1'b0,
    output logic [11:0]      pix_data = 12'h000
);
    int n = 0; // Pixels left in frame
    // Idle data toggles so a stale value never passes for a pixel
    always @(posedge mclk) begin
        pix_valid <= n > 0;
        pix_sof   <= n == W * H;
        pix_eol   <= n % W == 1;
        pix_data  <= n > 0 ? 12'($urandom) : ~pix_data;
        n         <= n > 0 ? n - 1 : (go ? W * H : 0);
    end
endmodule

// ### tb/dpc_sva.sv
// Checker: bus handshake and pixel stream timing at the top ports.
// Assumes one clock domain; checking pauses while ce is low.
`timescale 1ns/100ps
module dpc_sva (
    input wire logic        mclk, rst_b, ce, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        pix_valid, pix_sof, pix_eol, pixo_valid, pixo_sof, pixo_eol
);
    // Frozen flops under low ce would trip the timing checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b || !ce);
    ////////////////////////////////////////////////////////////////////////////////
    a_write_taken: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
    a_bvalid_cause: assert property (
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answer without request");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_b_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write answer not released");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_eol_out: assert property (
        pix_valid && pix_eol |-> ##2 pixo_valid && pixo_eol) else $error("line end lost");
    a_sof_out: assert property (
        pix_valid && pix_sof ##1 pix_valid |=> pixo_valid && pixo_sof)
        else $error("frame start lost");
endmodule
bind dpc_top dpc_sva u_dpc_sva (.*);

// ### tb/tb_top.sv
// Top bench: register tasks, frame runs, reference model of the correction.
// Assumes the design answers on its own handshakes; ce is held high.
`timescale 1ns/100ps
`include "dpc_defs.vh"
module tb_top;
    localparam int W = 40;
    localparam int H = 5;
    logic mclk = 0, rst_b = 0, go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF; // Whole words only
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic pix_valid, pix_sof, pix_eol, pixo_valid, pixo_sof, pixo_eol;
    logic [11:0] pix_data, pixo_data, inq[$], outq[$];
    int miscompares = 0, n_tests = 0, on, meth, ox = 0, oy = 0, tn, tc[16], tr[16];
    dpc_top u_dpc_top (.*, .ce(1'b1));
    dpc_src u_dpc_src (.*);
    always #2 mclk = ~mclk;
    // Capture both streams for the model
    always @(posedge mclk) begin
        if (pix_valid) inq.push_back(pix_data);
        if (pixo_valid) outq.push_back(pixo_data);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Each channel held until its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    // Poll busy; the watchdog bounds a hang
    task automatic idle;
        do rd(`DPC_A_STATUS); while (d[0] !== 1'b0);
    endtask
    task automatic reset;
        if (rst_b) idle; // A copy in flight finishes before power drops
        rst_b <= 0;
        repeat (20) @(posedge mclk);
        rst_b <= 1;
        idle;
        wr(`DPC_A_CTRL, on | meth << 2); // Control settings do not survive reset
    endtask
    task automatic fact;
        tn = `DPC_FACT_COUNT;
        tc[0] = `DPC_FACT_E0 & 12'hFFF;
        tr[0] = `DPC_FACT_E0 >> 12;
        tc[1] = `DPC_FACT_E1 & 12'hFFF;
        tr[1] = `DPC_FACT_E1 >> 12;
    endtask
    // Neighbours are the raw left and right pixels of the same line
    task automatic frame;
        int x, e, hit;
        inq = {};
        outq = {};
        @(posedge mclk) go <= 1;
        @(posedge mclk) go <= 0;
        wait (outq.size() == W * H);
        foreach (outq[i]) begin
            x = i % W;
            hit = 0;
            for (int j = 0; j < tn; j++) hit |= tc[j] == x + ox && tr[j] == i / W + oy;
            e = inq[i];
            if (on && hit) e = meth == 1 ? 'hFFF : x == 0 ? inq[i+1] : x == W - 1 ? inq[i-1]
                : (inq[i-1] + inq[i+1]) >> 1;
            chk(outq[i], e);
        end
    endtask
    task automatic complete_run;
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4bc7));
        reset;
        wr(`DPC_A_CMD, 4);
        idle;
        fact;
        rc(`DPC_A_STATUS, tn << `DPC_ST_CNT_LO);
        for (int m = 0; m < 3; m++) begin
            {on, meth} = {32'd1, m};
            wr(`DPC_A_CTRL, 1 | m << 2);
            frame;
        end
        on = 0;
        wr(`DPC_A_CTRL, 4);
        frame;
        on = 1;
        meth = 0;
        wr(`DPC_A_CTRL, 1);
        wr(`DPC_A_COUNT, 20);
        rc(`DPC_A_COUNT, 16);
        wr(`DPC_A_COUNT, 3);
        wr(`DPC_A_SELECT, 2);
        wr(`DPC_A_SELECT, 3);
        rc(`DPC_A_SELECT, 2);
        wr(`DPC_A_COL, 0);
        wr(`DPC_A_ROW, 2);
        rc(`DPC_A_ROW, 2);
        frame;
        wr(`DPC_A_CMD, 1);
        idle;
        {tn, tc[2], tr[2]} = {32'd3, 32'd0, 32'd2};
        frame;
        wr(`DPC_A_WINOFS, 32'h0001_0004);
        {ox, oy} = {32'd4, 32'd1};
        frame;
        wr(`DPC_A_WINOFS, 0);
        {ox, oy} = 64'd0;
        wr(`DPC_A_CMD, 2);
        reset;
        rc(`DPC_A_STATUS, 3 << `DPC_ST_CNT_LO);
        frame;
        wr(`DPC_A_COUNT, 1);
        wr(`DPC_A_CMD, 2);
        reset;
        tn = 1;
        frame;
        wr(`DPC_A_CMD, 4);
        reset;
        fact;
        frame;
        rc(8'hF0, 0);
        chk(r, `DPC_RESP_SLVERR);
        complete_run;
    end
    // Watchdog well beyond the expected run of some 2500 cycles
    initial begin
        repeat (50000) @(posedge mclk);
        miscompares++;
        complete_run;
    end
endmodule
